// ==== common/sdp_pkg.sv ====
// Purpose : Shared constants of the serial channel and its coding sublayer
// Assumes : One line bit per mclk cycle, transmitted first-bit-first (bit 9 of a code)
// Notes   : Code tables hold the negative-disparity form of each 8b/10b sub-block
package sdp_pkg;

   // ****************************************
   // Word widths
   // ****************************************
   localparam logic [3:0] LINE_W   = 4'hA;
   localparam logic [3:0] NARROW_W = 4'h8;
   localparam int         HALF_W   = 10;

   // ****************************************
   // Special characters
   // ****************************************
   localparam logic [6:0] COMMA_P  = 7'h1F;
   localparam logic [6:0] COMMA_N  = 7'h60;
   localparam logic [5:0] K28_6B   = 6'h0F;
   localparam logic [7:0] IDLE_CH  = 8'hBC;
   localparam logic [7:0] SKIP_CH  = 8'h1C;
   localparam logic [3:0] ALT7_P   = 4'h7;
   localparam logic [3:0] ALT7_N   = 4'h8;
   localparam logic [4:0] X_K28    = 5'h1C;
   localparam logic [4:0] X_FLIP   = 5'h07;
   localparam logic [2:0] Y_FLIP   = 3'h3;
   localparam logic [2:0] Y_ALT    = 3'h7;

   // ****************************************
   // 5b/6b and 3b/4b code tables
   // ****************************************
   localparam logic [0:31][5:0] CODE6 = {
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [0:7][3:0] CODE4 = {
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [3:0] CNT_RST  = 4'h0;
   localparam logic [3:0] CNT_SLIP = 4'hF;

endpackage

// ==== src/sdp_channel.sv ====
// Purpose : One serial channel with receive/transmit coding sublayer and fabric interface
// Assumes : Line runs one bit per mclk; configuration inputs come from mclk-domain logic
// Notes   : Recovered and transmit word clocks are divided from mclk and driven out
`timescale 1ns/1ps

module sdp_channel #(
   parameter int DEPTH = 4
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        sd_rx,
   output logic             sd_tx,
   input  wire logic        cfg_bypass,
   input  wire logic        cfg_wide10,
   input  wire logic        cfg_half,
   input  wire logic        cfg_rx_inv,
   input  wire logic        cfg_tx_inv,
   input  wire logic        cfg_align_en,
   input  wire logic        cfg_direct,
   input  wire logic        rx_bitslip,
   output logic [19:0]      rx_data,
   output logic [1:0]       rx_k,
   output logic [1:0]       rx_err,
   output logic             rx_valid,
   output logic             rx_word_clk,
   output logic             rx_raw,
   input  wire logic [19:0] tx_data,
   input  wire logic [1:0]  tx_k,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic             tx_word_clk,
   input  wire logic        tx_raw
);

   localparam int               PW        = $clog2(DEPTH) + 1;
   localparam int               AW        = PW - 1;
   localparam logic [PW-1:0]    FULL_MARK = PW'(DEPTH - 1);
   localparam logic [PW-1:0]    DEPTH_P   = PW'(DEPTH);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic                    rx_s1;
      logic                    rx_s2;
      logic [9:0]              rx_sh;
      logic [3:0]              rx_cnt;
      logic                    slip_pend;
      logic [DEPTH-1:0][11:0]  mem;
      logic [PW-1:0]           wp;
      logic [PW-1:0]           rp;
      logic [19:0]             rx_data;
      logic [1:0]              rx_k;
      logic [1:0]              rx_err;
      logic                    rx_valid;
      logic                    rx_word_clk;
      logic                    rx_raw;
      logic [9:0]              tx_sh;
      logic [3:0]              tx_cnt;
      logic [19:0]             tx_hold;
      logic [1:0]              tx_holdk;
      logic [1:0]              tx_n;
      logic                    rd_tx;
      logic                    tx_ready;
      logic                    tx_word_clk;
      logic                    sd_tx;
   } sdp_state_t;

   sdp_state_t s;
   sdp_state_t next_s;

   // ****************************************
   // 8b/10b helpers
   // ****************************************
   function automatic logic unbal6(input logic [5:0] c);
      return $countones(c) != 3;
   endfunction

   function automatic logic unbal4(input logic [3:0] c);
      return $countones(c) != 2;
   endfunction

   // Returns {running disparity after, code}
   function automatic logic [10:0] sdp_enc(input logic [7:0] d, input logic k,
                                          input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic       rd1;
      c6 = k ? sdp_pkg::K28_6B : sdp_pkg::CODE6[d[4:0]];
      if (rd && (unbal6(c6) || (!k && d[4:0] == sdp_pkg::X_FLIP))) begin
         c6 = ~c6;
      end
      rd1 = rd ^ unbal6(c6);
      c4 = sdp_pkg::CODE4[d[7:5]];
      if (k) begin
         // Control groups: balanced ones other than Y_FLIP track entering disparity; unbalanced ones and Y_FLIP the 6-bit result
         if (d[7:5] == sdp_pkg::Y_ALT) begin
            c4 = sdp_pkg::ALT7_P;
         end
         if ((unbal4(c4) || d[7:5] == sdp_pkg::Y_FLIP) ? rd1 : rd) begin
            c4 = ~c4;
         end
      end else if (rd1 && (unbal4(c4) || d[7:5] == sdp_pkg::Y_FLIP)) begin
         c4 = ~c4;
      end
      return {rd1 ^ unbal4(c4), c6, c4};
   endfunction

   // Returns {code error, control flag, byte}
   function automatic logic [9:0] sdp_dec(input logic [9:0] c);
      logic [5:0] c6;
      logic [3:0] c4;
      logic [4:0] x;
      logic [2:0] y;
      logic       h6;
      logic       h4;
      logic       k;
      c6 = c[9:4];
      c4 = c[3:0];
      x  = '0;
      y  = '0;
      h6 = 1'b0;
      h4 = 1'b0;
      k  = (c6 == sdp_pkg::K28_6B) || (c6 == ~sdp_pkg::K28_6B);
      for (int i = 0; i < 32; i++) begin
         if (sdp_pkg::CODE6[i] == c6 || ((unbal6(sdp_pkg::CODE6[i]) ||
             5'(i) == sdp_pkg::X_FLIP) && ~sdp_pkg::CODE6[i] == c6)) begin
            x  = 5'(i);
            h6 = 1'b1;
         end
      end
      if (k) begin
         x  = sdp_pkg::X_K28;
         h6 = 1'b1;
         if (c6 != sdp_pkg::K28_6B) begin
            c4 = ~c4;
         end
      end
      for (int j = 0; j < 8; j++) begin
         if (sdp_pkg::CODE4[j] == c4 || ((unbal4(sdp_pkg::CODE4[j]) ||
             3'(j) == sdp_pkg::Y_FLIP) && ~sdp_pkg::CODE4[j] == c4)) begin
            y  = 3'(j);
            h4 = 1'b1;
         end
      end
      if ((!k && (c4 == sdp_pkg::ALT7_P || c4 == sdp_pkg::ALT7_N)) ||
          (k && c4 == sdp_pkg::ALT7_N)) begin
         y  = sdp_pkg::Y_ALT;
         h4 = 1'b1;
      end
      return {~(h6 & h4), k, y, x};
   endfunction

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic [3:0]    wlen;
      logic          coded;
      logic          bit_in;
      logic [9:0]    sh_n;
      logic          comma;
      logic          wdone;
      logic [9:0]    word;
      logic [9:0]    dw;
      logic [11:0]   entry;
      logic [PW-1:0] fill;
      logic [PW-1:0] need;
      logic [AW-1:0] r0;
      logic [AW-1:0] r1;
      logic          skip;
      logic          tdone;
      logic          hi;
      logic [9:0]    wd;
      logic          wk;
      logic [10:0]   enc;
      logic [9:0]    code;
      next_s = s;
      wlen   = (cfg_bypass && !cfg_wide10) ? sdp_pkg::NARROW_W : sdp_pkg::LINE_W;
      coded  = !cfg_bypass;
      bit_in = s.rx_s2 ^ cfg_rx_inv;
      sh_n   = {s.rx_sh[8:0], bit_in};
      comma  = coded && cfg_align_en &&
               (sh_n[9:3] == sdp_pkg::COMMA_P || sh_n[9:3] == sdp_pkg::COMMA_N);
      wdone  = (s.rx_cnt == wlen - 4'h1) || comma;
      word   = (wlen == sdp_pkg::NARROW_W) ? {2'b00, sh_n[7:0]} : sh_n;
      dw     = sdp_dec(word);
      entry  = coded ? {dw[9:8], 2'b00, dw[7:0]} : {2'b00, word};
      fill   = s.wp - s.rp;
      need   = cfg_half ? PW'(2) : PW'(1);
      r0     = s.rp[AW-1:0];
      r1     = AW'(s.rp + PW'(1));
      skip   = coded && dw[8] && dw[7:0] == sdp_pkg::SKIP_CH && fill >= FULL_MARK;

      // ****************************************
      // Receive: sync, deserialize, slip
      // ****************************************
      next_s.rx_s1  = sd_rx;
      next_s.rx_s2  = s.rx_s1;
      next_s.rx_raw = s.rx_s2;
      next_s.rx_sh  = sh_n;
      next_s.slip_pend = s.slip_pend | rx_bitslip;
      if (wdone) begin
         // A pending slip stretches the next word by one bit only
         next_s.rx_cnt    = s.slip_pend ? sdp_pkg::CNT_SLIP : sdp_pkg::CNT_RST;
         next_s.slip_pend = rx_bitslip;
      end else begin
         next_s.rx_cnt = s.rx_cnt + 4'h1;
      end
      next_s.rx_word_clk = s.rx_cnt < {1'b0, wlen[3:1]};

      // ****************************************
      // Receive: rate compensation and FIFO
      // ****************************************
      next_s.rx_valid = 1'b0;
      if (fill >= need) begin
         next_s.rx_valid = 1'b1;
         if (cfg_half) begin
            next_s.rx_data = {s.mem[r1][9:0], s.mem[r0][9:0]};
            next_s.rx_k    = {s.mem[r1][10], s.mem[r0][10]};
            next_s.rx_err  = {s.mem[r1][11], s.mem[r0][11]};
         end else begin
            next_s.rx_data = {10'h000, s.mem[r0][9:0]};
            next_s.rx_k    = {1'b0, s.mem[r0][10]};
            next_s.rx_err  = {1'b0, s.mem[r0][11]};
         end
         next_s.rp = s.rp + need;
      end
      // Skip characters are dropped once fill reaches FULL_MARK; any word is dropped while the FIFO is full
      if (wdone && !skip && fill < DEPTH_P) begin
         next_s.mem[s.wp[AW-1:0]] = entry;
         next_s.wp = s.wp + PW'(1);
      end

      // ****************************************
      // Transmit: fabric side
      // ****************************************
      if (tx_valid && s.tx_ready) begin
         next_s.tx_hold  = tx_data;
         next_s.tx_holdk = tx_k;
         next_s.tx_n     = cfg_half ? 2'd2 : 2'd1;
      end

      // ****************************************
      // Transmit: encode, polarity, serialize
      // ****************************************
      tdone = s.tx_cnt == wlen - 4'h1;
      hi    = cfg_half && s.tx_n == 2'd1;
      wd    = hi ? s.tx_hold[19:10] : s.tx_hold[9:0];
      wk    = hi ? s.tx_holdk[1] : s.tx_holdk[0];
      if (s.tx_n == 2'd0) begin
         // Nothing queued: send idle commas, or zeros in bypass
         wd = coded ? {2'b00, sdp_pkg::IDLE_CH} : 10'h000;
         wk = coded;
      end
      enc  = sdp_enc(wd[7:0], wk, s.rd_tx);
      code = coded ? enc[9:0] :
             ((wlen == sdp_pkg::NARROW_W) ? {wd[7:0], 2'b00} : wd);
      next_s.tx_cnt = tdone ? sdp_pkg::CNT_RST : s.tx_cnt + 4'h1;
      next_s.tx_sh  = {s.tx_sh[8:0], 1'b0};
      if (tdone) begin
         next_s.tx_sh = code ^ {10{cfg_tx_inv}};
         if (coded) begin
            next_s.rd_tx = enc[10];
         end
         if (s.tx_n != 2'd0) begin
            next_s.tx_n = s.tx_n - 2'd1;
         end
      end
      next_s.tx_ready    = next_s.tx_n == 2'd0;
      next_s.tx_word_clk = s.tx_cnt < {1'b0, wlen[3:1]};
      next_s.sd_tx       = cfg_direct ? tx_raw : s.tx_sh[9];
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign sd_tx       = s.sd_tx;
   assign rx_data     = s.rx_data;
   assign rx_k        = s.rx_k;
   assign rx_err      = s.rx_err;
   assign rx_valid    = s.rx_valid;
   assign rx_word_clk = s.rx_word_clk;
   assign rx_raw      = s.rx_raw;
   assign tx_ready    = s.tx_ready;
   assign tx_word_clk = s.tx_word_clk;

endmodule

// ==== tb/sdp_channel_properties.sv ====
// Purpose : Port assertions of the serial channel
// Assumes : Configuration changes only while arst_n is low
// Notes   : Bound to every sdp_channel instance
`timescale 1ns/1ps
module sdp_channel_chk (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        sd_rx,
   input wire logic        sd_tx,
   input wire logic        cfg_bypass,
   input wire logic        cfg_wide10,
   input wire logic        cfg_half,
   input wire logic        cfg_direct,
   input wire logic        tx_raw,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic        tx_word_clk,
   input wire logic        rx_raw,
   input wire logic        rx_word_clk,
   input wire logic [19:0] rx_data,
   input wire logic        rx_valid
);
   // ****************************************
   // Word clock shapes and port checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence word10_s;
      tx_word_clk [*5] ##1 !tx_word_clk [*5] ##1 tx_word_clk;
   endsequence
   sequence word8_s;
      tx_word_clk [*4] ##1 !tx_word_clk [*4] ##1 tx_word_clk;
   endsequence
   sequence rx_word10_s;
      rx_word_clk [*5] ##1 !rx_word_clk;
   endsequence

   word_ten_a: assert property ($rose(tx_word_clk) && cfg_wide10 |-> word10_s)
      else $error("ten bit word clock off");
   word_eight_a: assert property (cfg_bypass && !cfg_wide10 && $rose(tx_word_clk)
      |-> word8_s)
      else $error("eight bit word clock off");
   rx_word_a: assert property ($rose(rx_word_clk) && cfg_bypass && cfg_wide10
      |-> rx_word10_s)
      else $error("receive word clock off");
   ready_drop_a: assert property (tx_valid && tx_ready |=> !tx_ready)
      else $error("ready held after take");
   ready_back_a: assert property ($fell(tx_ready) |-> ##[1:21] tx_ready)
      else $error("ready not restored");
   ready_reset_a: assert property (!$past(arst_n) |=> tx_ready)
      else $error("ready missing after reset");
   direct_follow_a: assert property (cfg_direct && $past(arst_n)
      |-> sd_tx == $past(tx_raw))
      else $error("direct path not one flop");
   raw_path_a: assert property ($past(arst_n, 3) && $past(arst_n, 2) && $past(arst_n)
      |-> rx_raw == $past(sd_rx, 3))
      else $error("raw path not three flops");
   rx_upper_a: assert property (rx_valid && !cfg_half |-> rx_data[19:10] == 10'h000)
      else $error("upper half not zero");
endmodule

bind sdp_channel sdp_channel_chk u_chk (.mclk, .arst_n, .sd_rx, .sd_tx, .cfg_bypass,
   .cfg_wide10, .cfg_half, .cfg_direct, .tx_raw, .tx_valid, .tx_ready, .tx_word_clk,
   .rx_raw, .rx_data, .rx_valid, .rx_word_clk);

// ==== tb/sdp_far_end.sv ====
// Purpose : Remote transceiver model that echoes the line
// Assumes : Same bit rate as the channel
// Notes   : slow adds one more bit period of lag
`timescale 1ns/1ps
module sdp_far_end (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic slow,
   input  wire logic line_in,
   output logic      line_out
);
   logic [1:0] lag;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lag <= 2'h0;
      end else begin
         lag <= {lag[0], line_in};
      end
   end
   assign line_out = slow ? lag[1] : lag[0];
endmodule

// ==== tb/sdp_channel_tb.sv ====
// Purpose : Self-checking bench of the serial channel in loopback
// Assumes : Far end echoes the line; config changes only under reset
// Notes   : Coded, inverted, half rate, bypass slip and direct runs
`timescale 1ns/1ps
module sdp_channel_tb;
   logic        mclk = 1'b0, arst_n = 1'b0, far_slow = 1'b0, sd_rx, sd_tx;
   logic        cfg_bypass = 1'b0, cfg_wide10 = 1'b1, cfg_half = 1'b0, cfg_rx_inv = 1'b0;
   logic        cfg_tx_inv = 1'b0, cfg_align_en = 1'b1, cfg_direct = 1'b0, tx_raw = 1'b0;
   logic        rx_bitslip = 1'b0, rx_valid, rx_word_clk, rx_raw, tx_ready, tx_word_clk;
   logic        tx_valid = 1'b0;
   logic [19:0] rx_data, tx_data = 20'h0_0000;
   logic [1:0]  rx_k, rx_err, tx_k = 2'h0;
   int          bad_count = 0, n_compared = 0;

   always #12.5 mclk = ~mclk;

   sdp_channel #(.DEPTH(4)) uut (.mclk, .arst_n, .sd_rx, .sd_tx, .cfg_bypass, .cfg_wide10,
      .cfg_half, .cfg_rx_inv, .cfg_tx_inv, .cfg_align_en, .cfg_direct, .rx_bitslip, .rx_data,
      .rx_k, .rx_err, .rx_valid, .rx_word_clk, .rx_raw, .tx_data, .tx_k, .tx_valid,
      .tx_ready, .tx_word_clk, .tx_raw);
   sdp_far_end far (.mclk, .arst_n, .slow(far_slow), .line_in(sd_tx), .line_out(sd_rx));

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic setup(input logic byp, w10, hf, inv, aln, dir);
      {cfg_bypass, cfg_wide10, cfg_half, cfg_rx_inv, cfg_tx_inv} = {byp, w10, hf, inv, inv};
      {cfg_align_en, cfg_direct, far_slow, arst_n} = {aln, dir, inv, 1'b0};
      repeat (5) @(posedge mclk);
      #1;
      chk({17'h0_0000, tx_ready, rx_valid, sd_tx}, 20'h0_0000);
      arst_n = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // Leaves tx_valid high so back-to-back words need no idle gap
   task automatic send(input logic [19:0] d);
      int   i;
      logic rdy;
      i = 0;
      tx_data = d;
      tx_valid = 1'b1;
      do begin
         // Ready is settled here; the word is taken at the edge that follows
         rdy = tx_ready;
         @(posedge mclk);
         #1;
         i++;
      end while (rdy !== 1'b1 && i < 40);
      chk({19'h0_0000, rdy}, 20'h0_0001);
   endtask

   task automatic next_word;
      int i;
      i = 0;
      do begin
         @(posedge mclk);
         #1;
         i++;
      end while (rx_valid !== 1'b1 && i < 400);
      chk({19'h0_0000, rx_valid}, 20'h0_0001);
   endtask

   task automatic t_coded(input logic hf, inv);
      logic [7:0] b [4] = '{8'h00, 8'hA5, 8'hFF, 8'h3C};
      logic       idle_seen;
      int         got;
      idle_seen = 1'b0;
      got = 0;
      setup(1'b0, 1'b1, hf, inv, 1'b1, 1'b0);
      repeat (60) @(posedge mclk);
      #1;
      fork
         begin
            for (int j = 0; j < 4; j++) begin
               send(hf ? 20'h1_9866 : {12'h000, b[j]});
            end
            tx_valid = 1'b0;
         end
         while (got < (hf ? 3 : 4)) begin
            next_word;
            if (rx_k[0] === 1'b1 && !idle_seen) begin
               idle_seen = 1'b1;
               chk({10'h000, rx_data[9:0]}, {12'h000, sdp_pkg::IDLE_CH});
            end
            if (rx_k === 2'h0) begin
               chk(rx_data, hf ? 20'h1_9866 : {12'h000, b[got]});
               chk({18'h0_0000, rx_err}, 20'h0_0000);
               got++;
            end
         end
      join
      $display("coded test done, half %0d inverted %0d", hf, inv);
   endtask

   task automatic t_slip(input logic wide);
      logic [9:0] w, rot;
      int         s;
      w = wide ? 10'h0F3 : 10'h01D;
      rot = wide ? {w[8:0], w[9]} : {2'h0, w[6:0], w[7]};
      s = 0;
      setup(1'b1, wide, 1'b0, 1'b0, 1'b0, 1'b0);
      send({10'h000, w});
      next_word;
      next_word;
      while (rx_data[9:0] !== w && s < 12) begin
         rx_bitslip = 1'b1;
         @(posedge mclk);
         #1;
         rx_bitslip = 1'b0;
         next_word;
         next_word;
         s++;
      end
      chk(rx_data, {10'h000, w});
      rx_bitslip = 1'b1;
      @(posedge mclk);
      #1;
      rx_bitslip = 1'b0;
      next_word;
      chk(rx_data, {10'h000, w});
      next_word;
      chk(rx_data, {10'h000, rot});
      tx_valid = 1'b0;
      $display("bypass slip test done, ten bit %0d", wide);
   endtask

   task automatic t_direct;
      setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      for (int j = 0; j < 8; j++) begin
         tx_raw = j[0] ^ j[2];
         @(posedge mclk);
         #1;
         chk({19'h0_0000, sd_tx}, {19'h0_0000, tx_raw});
      end
      $display("direct test done");
   endtask

   initial begin
      t_coded(1'b0, 1'b0);
      t_coded(1'b0, 1'b1);
      t_coded(1'b1, 1'b0);
      t_slip(1'b1);
      t_slip(1'b0);
      t_direct;
      close_out;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      close_out;
   end
endmodule
